// *** bit_set_or_test_skip_exec.sv ***
// Overview of operation
// - Set writes one, other nibble bits kept
// - Set reaches direct and indirect bits, ports too
// - Every set form: two bytes, two cycles
// - Pointer form: operand 5-2, pointer 3-2, bit 1-0
// - Paged form: high pointer plus operand low nibble
// - OR form: carry becomes carry OR bit
// - OR form never writes its source
// - OR: window, pointer, paged forms; two cycles
// - Test-skip: bit zero suppresses next instruction
// - Test-skip: bit one lets next execute
// - Test-skip only reads, never writes
// - Test-skip: two bytes, two cycles plus skip
`timescale 1ns/1ps
`default_nettype none

module bit_set_or_test_skip_exec (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        instr_valid,
    input  wire logic [7:0]  first_byte,
    input  wire logic [7:0]  second_byte,
    input  wire logic [3:0]  ptr_high,
    input  wire logic [3:0]  ptr_low,
    input  wire logic        carry_in,
    input  wire logic [3:0]  mem_rdata,
    output logic             busy,
    output logic             mem_rd,
    output logic             mem_wr,
    output logic [11:0]      mem_addr,
    output logic [3:0]       mem_wdata,
    output logic             carry_wr,
    output logic             carry_out,
    output logic             skip_next,
    output logic             done,
    output logic             illegal
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic {ST_IDLE, ST_EXEC} phase_t;

    typedef struct packed {
        phase_t            phase;
        bit_exec_pkg::op_t op;
        logic [1:0]        bit_num;
        logic              carry;
        logic              busy;
        logic              mem_rd;
        logic              mem_wr;
        logic [11:0]       mem_addr;
        logic [3:0]        mem_wdata;
        logic              carry_wr;
        logic              carry_out;
        logic              skip_next;
        logic              done;
        logic              illegal;
    } state_t;

    state_t cur;
    state_t next_cur;

    logic              dec_legal;
    bit_exec_pkg::op_t dec_op;
    logic [11:0]       dec_addr;
    logic [1:0]        dec_bit;
    logic              src_bit;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    bit_operand_decode u_decode (
        .first_byte  (first_byte),
        .second_byte (second_byte),
        .ptr_high    (ptr_high),
        .ptr_low     (ptr_low),
        .legal       (dec_legal),
        .op          (dec_op),
        .bit_addr    (dec_addr),
        .bit_num     (dec_bit)
    );

    assign src_bit = mem_rdata[cur.bit_num];

    // ------------------------------------------------------------
    // Two-cycle sequence: read in cycle 1, act in cycle 2
    // ------------------------------------------------------------
    always_comb begin
        next_cur           = cur;
        next_cur.mem_wr    = 1'b0;
        next_cur.carry_wr  = 1'b0;
        next_cur.skip_next = 1'b0;
        next_cur.done      = 1'b0;
        next_cur.illegal   = 1'b0;
        case (cur.phase)
            ST_IDLE: begin
                if (instr_valid && dec_legal) begin
                    next_cur.phase    = ST_EXEC;
                    next_cur.op       = dec_op;
                    next_cur.bit_num  = dec_bit;
                    next_cur.carry    = carry_in;
                    next_cur.busy     = 1'b1;
                    next_cur.mem_rd   = 1'b1;
                    next_cur.mem_addr = dec_addr;
                end else if (instr_valid) begin
                    // Unknown encodings are flagged, nothing is touched
                    next_cur.illegal  = 1'b1;
                end
            end
            ST_EXEC: begin
                next_cur.phase  = ST_IDLE;
                next_cur.busy   = 1'b0;
                next_cur.mem_rd = 1'b0;
                next_cur.done   = 1'b1;
                case (cur.op)
                    bit_exec_pkg::OP_SET: begin
                        // Read-modify-write keeps neighbouring bits
                        next_cur.mem_wdata = mem_rdata | (4'h1 << cur.bit_num);
                        next_cur.mem_wr    = 1'b1;
                    end
                    bit_exec_pkg::OP_OR: begin
                        next_cur.carry_out = cur.carry | src_bit;
                        next_cur.carry_wr  = 1'b1;
                    end
                    bit_exec_pkg::OP_SKIP: begin
                        next_cur.skip_next = ~src_bit;
                    end
                    default: begin
                        next_cur.done = 1'b1;
                    end
                endcase
            end
            default: begin
                next_cur.phase = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign busy      = cur.busy;
    assign mem_rd    = cur.mem_rd;
    assign mem_wr    = cur.mem_wr;
    assign mem_addr  = cur.mem_addr;
    assign mem_wdata = cur.mem_wdata;
    assign carry_wr  = cur.carry_wr;
    assign carry_out = cur.carry_out;
    assign skip_next = cur.skip_next;
    assign done      = cur.done;
    assign illegal   = cur.illegal;

endmodule : bit_set_or_test_skip_exec
`default_nettype wire

// *** bit_exec_pkg.sv ***
package bit_exec_pkg;

    // ------------------------------------------------------------
    // Opcodes and field layout
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_SET_IND   = 8'hFF;
    localparam logic [7:0] OPC_OR_IND    = 8'hF6;
    localparam logic [7:0] OPC_SKIP_IND  = 8'hF8;
    localparam logic [1:0] DIRECT_PREFIX = 2'h3;
    localparam logic [3:0] DIRECT_SET    = 4'h1;
    localparam logic [3:0] DIRECT_SKIP   = 4'h2;
    localparam logic [1:0] SB_PAGED      = 2'h0;
    localparam logic [1:0] SB_WIN_LO     = 2'h2;
    localparam logic [1:0] SB_WIN_HI     = 2'h3;
    localparam logic [3:0] SB_PTR_MARK   = 4'h4;
    localparam logic [3:0] WIN_LO_PAGE   = 4'hB;
    localparam logic [3:0] WIN_HI_PAGE   = 4'hF;
    localparam logic [3:0] PAGE_TOP      = 4'hF;
    localparam int         INSTR_CYCLES  = 2;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_SET,
        OP_OR,
        OP_SKIP
    } op_t;

endpackage : bit_exec_pkg

// *** bit_operand_decode.sv ***
`timescale 1ns/1ps
`default_nettype none

module bit_operand_decode (
    input  wire logic [7:0]       first_byte,
    input  wire logic [7:0]       second_byte,
    input  wire logic [3:0]       ptr_high,
    input  wire logic [3:0]       ptr_low,
    output var  logic             legal,
    output var  bit_exec_pkg::op_t op,
    output var  logic [11:0]      bit_addr,
    output var  logic [1:0]       bit_num
);

    // ------------------------------------------------------------
    // Opcode and operand form decode
    // ------------------------------------------------------------
    logic ind_form;
    logic [1:0] sb_top;

    always_comb begin
        sb_top   = second_byte[7:6];
        ind_form = 1'b0;
        legal    = 1'b0;
        op       = bit_exec_pkg::OP_NONE;
        bit_addr = 12'h000;
        bit_num  = 2'h0;
        if (first_byte == bit_exec_pkg::OPC_SET_IND) begin
            ind_form = 1'b1;
            op       = bit_exec_pkg::OP_SET;
        end else if (first_byte == bit_exec_pkg::OPC_OR_IND) begin
            ind_form = 1'b1;
            op       = bit_exec_pkg::OP_OR;
        end else if (first_byte == bit_exec_pkg::OPC_SKIP_IND) begin
            ind_form = 1'b1;
            op       = bit_exec_pkg::OP_SKIP;
        end else if (first_byte[7:6] == bit_exec_pkg::DIRECT_PREFIX
                     && first_byte[3:0] == bit_exec_pkg::DIRECT_SET) begin
            op       = bit_exec_pkg::OP_SET;
            legal    = 1'b1;
            bit_addr = {4'h0, second_byte};
            bit_num  = first_byte[5:4];
        end else if (first_byte[7:6] == bit_exec_pkg::DIRECT_PREFIX
                     && first_byte[3:0] == bit_exec_pkg::DIRECT_SKIP) begin
            op       = bit_exec_pkg::OP_SKIP;
            legal    = 1'b1;
            bit_addr = {4'h0, second_byte};
            bit_num  = first_byte[5:4];
        end
        // Short window, pointer and paged forms share one second byte
        if (ind_form) begin
            legal = 1'b1;
            if (sb_top == bit_exec_pkg::SB_WIN_LO) begin
                bit_addr = {bit_exec_pkg::PAGE_TOP, bit_exec_pkg::WIN_LO_PAGE,
                            second_byte[3:0]};
                bit_num  = second_byte[5:4];
            end else if (sb_top == bit_exec_pkg::SB_WIN_HI) begin
                bit_addr = {bit_exec_pkg::PAGE_TOP, bit_exec_pkg::WIN_HI_PAGE,
                            second_byte[3:0]};
                bit_num  = second_byte[5:4];
            end else if (second_byte[7:4] == bit_exec_pkg::SB_PTR_MARK) begin
                // Base of six bits comes from the window area FC0H-FFFH
                bit_addr = {bit_exec_pkg::PAGE_TOP, bit_exec_pkg::WIN_HI_PAGE[3:2],
                            second_byte[3:0], ptr_low[3:2]};
                bit_num  = ptr_low[1:0];
            end else if (sb_top == bit_exec_pkg::SB_PAGED) begin
                bit_addr = {4'h0, ptr_high, second_byte[3:0]};
                bit_num  = second_byte[5:4];
            end else begin
                legal    = 1'b0;
                op       = bit_exec_pkg::OP_NONE;
            end
        end
    end

endmodule : bit_operand_decode
`default_nettype wire

// *** bit_exec_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none

module bit_exec_assertions (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        instr_valid,
    input wire logic [7:0]  first_byte,
    input wire logic [7:0]  second_byte,
    input wire logic [3:0]  ptr_high,
    input wire logic [3:0]  ptr_low,
    input wire logic        carry_in,
    input wire logic [3:0]  mem_rdata,
    input wire logic        busy,
    input wire logic        mem_rd,
    input wire logic        mem_wr,
    input wire logic [11:0] mem_addr,
    input wire logic [3:0]  mem_wdata,
    input wire logic        carry_wr,
    input wire logic        carry_out,
    input wire logic        skip_next,
    input wire logic        done,
    input wire logic        illegal
);
    // ------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Accepted indirect set (first byte FFH) forms and their operand fields
    wire logic       take  = instr_valid && !busy && first_byte == 8'hFF;
    wire logic [3:0] sb_lo = second_byte[3:0];
    wire logic [1:0] l_hi  = ptr_low[3:2];

    property p_take; instr_valid && !busy |=> (busy && mem_rd) != illegal; endproperty
    a_take: assert property (p_take) else $error("no answer");
    property p_two; $rose(busy) |=> done && !busy && !mem_rd; endproperty
    a_two: assert property (p_two) else $error("not two cycles");
    // At most one bit may change, and only towards one
    property p_set; mem_wr |-> $onehot0(mem_wdata ^ $past(mem_rdata))
        && (mem_wdata & $past(mem_rdata)) == $past(mem_rdata) && !carry_wr; endproperty
    a_set: assert property (p_set) else $error("bad write");
    property p_cy; carry_wr && $past(carry_in, 2) |-> carry_out && !mem_wr; endproperty
    a_cy: assert property (p_cy) else $error("carry lost");
    property p_sk; skip_next |-> done && !mem_wr && $past(mem_rdata) != 4'hF; endproperty
    a_sk: assert property (p_sk) else $error("bad skip");
    property p_win; take && second_byte[7:6] == 2'h3 |=> mem_addr == {8'hFF, $past(sb_lo)};
    endproperty
    a_win: assert property (p_win) else $error("window addr");
    property p_ptr; take && second_byte[7:4] == 4'h4
        |=> mem_addr == {6'h3F, $past(sb_lo), $past(l_hi)}; endproperty
    a_ptr: assert property (p_ptr) else $error("pointer addr");
    property p_pg; take && second_byte[7:6] == 2'h0
        |=> mem_addr == {4'h0, $past(ptr_high), $past(sb_lo)}; endproperty
    a_pg: assert property (p_pg) else $error("paged addr");
endmodule : bit_exec_assertions

bind bit_set_or_test_skip_exec bit_exec_assertions u_chk (.sys_clk(sys_clk), .reset(reset),
    .instr_valid(instr_valid), .first_byte(first_byte), .second_byte(second_byte),
    .ptr_high(ptr_high), .ptr_low(ptr_low), .carry_in(carry_in), .mem_rdata(mem_rdata),
    .busy(busy), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .done(done),
    .mem_wdata(mem_wdata), .carry_wr(carry_wr), .carry_out(carry_out),
    .skip_next(skip_next), .illegal(illegal));

`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    // ------------------------------------------------------------
    // Stimulus and checking
    // ------------------------------------------------------------
    logic        sys_clk = 1'b0, reset = 1'b1, instr_valid = 1'b0, carry_in = 1'b0;
    logic [7:0]  first_byte = 8'h00, second_byte = 8'h00;
    logic [3:0]  ptr_high = 4'h0, ptr_low = 4'h0, mem_rdata = 4'h0, mem_wdata;
    logic        busy, mem_rd, mem_wr, carry_wr, carry_out, skip_next, done, illegal;
    logic [11:0] mem_addr;
    int          fail_count = 0, num_checks = 0;

    bit_set_or_test_skip_exec dut (.sys_clk(sys_clk), .reset(reset), .instr_valid(instr_valid),
        .first_byte(first_byte), .second_byte(second_byte), .ptr_high(ptr_high),
        .ptr_low(ptr_low), .carry_in(carry_in), .mem_rdata(mem_rdata), .busy(busy),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .carry_wr(carry_wr), .carry_out(carry_out), .skip_next(skip_next), .done(done),
        .illegal(illegal));

    // 10 MHz clock
    initial forever #50 sys_clk = ~sys_clk;

    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // One instruction; f = {hold, illegal, write, carry write, carry, skip}
    task automatic run(input logic [7:0] fb, sb, input logic [3:0] h, l, rd, input logic c,
                       input logic [11:0] ea, input logic [3:0] ew, input logic [5:0] f);
        @(posedge sys_clk);
        {instr_valid, first_byte, second_byte, ptr_high, ptr_low} <= {1'b1, fb, sb, h, l};
        carry_in <= c;
        @(posedge sys_clk);
        instr_valid <= f[5];
        mem_rdata <= rd;
        #1 chk("busy", 12'(!f[4]), 12'(busy));
        chk("rd", 12'(!f[4]), 12'(mem_rd));
        chk("illegal", 12'(f[4]), 12'(illegal));
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        mem_rdata <= ~rd; // Released bus shows no stale value
        #1 chk("done", 12'(!f[4]), 12'(done));
        chk("busy2", 12'h000, 12'(busy));
        chk("rd2", 12'h000, 12'(mem_rd));
        chk("wr", 12'(f[3]), 12'(mem_wr));
        chk("cwr", 12'(f[2]), 12'(carry_wr));
        chk("skip", 12'(f[0]), 12'(skip_next));
        if (!f[4]) chk("addr", ea, mem_addr);
        if (f[3]) chk("wdata", 12'(ew), 12'(mem_wdata));
        if (f[2]) chk("carry", 12'(f[1]), 12'(carry_out));
    endtask : run

    task automatic t_set;
        run(8'hE1, 8'h30, 4'h0, 4'h0, 4'h0, 1'b0, 12'h030, 4'h4, 6'h08);
        run(8'hD1, 8'hFF, 4'h0, 4'h0, 4'hF, 1'b0, 12'h0FF, 4'hF, 6'h08);
        run(8'hFF, 8'hC0, 4'h0, 4'h0, 4'hA, 1'b0, 12'hFF0, 4'hB, 6'h08);
        run(8'hFF, 8'hB5, 4'h0, 4'h0, 4'h1, 1'b0, 12'hFB5, 4'h9, 6'h08);
        run(8'hFF, 8'h4C, 4'h0, 4'h5, 4'h0, 1'b0, 12'hFF1, 4'h2, 6'h08);
        run(8'hFF, 8'h10, 4'h2, 4'h0, 4'h8, 1'b0, 12'h020, 4'hA, 6'h28);
    endtask : t_set

    task automatic t_or;
        run(8'hF6, 8'hB3, 4'h0, 4'h0, 4'h8, 1'b0, 12'hFB3, 4'h0, 6'h06);
        run(8'hF6, 8'h4A, 4'h0, 4'h3, 4'h7, 1'b0, 12'hFE8, 4'h0, 6'h04);
        run(8'hF6, 8'h23, 4'h5, 4'h0, 4'h0, 1'b1, 12'h053, 4'h0, 6'h06);
    endtask : t_or

    task automatic t_skip;
        run(8'hF8, 8'hC7, 4'h0, 4'h0, 4'hE, 1'b0, 12'hFF7, 4'h0, 6'h01);
        run(8'hF8, 8'hD7, 4'h0, 4'h0, 4'hE, 1'b0, 12'hFF7, 4'h0, 6'h00);
        run(8'hF2, 8'h44, 4'h0, 4'h0, 4'h7, 1'b0, 12'h044, 4'h0, 6'h01);
        run(8'hF8, 8'h4E, 4'h0, 4'hB, 4'h8, 1'b0, 12'hFFA, 4'h0, 6'h00);
        run(8'hF8, 8'h31, 4'h9, 4'h0, 4'h0, 1'b0, 12'h091, 4'h0, 6'h01);
    endtask : t_skip

    task automatic t_bad;
        run(8'hFF, 8'h50, 4'h0, 4'h0, 4'h0, 1'b0, 12'h000, 4'h0, 6'h10);
        run(8'h00, 8'h30, 4'h0, 4'h0, 4'h0, 1'b0, 12'h000, 4'h0, 6'h10);
    endtask : t_bad

    // Reset in mid-instruction clears every output, then work resumes
    task automatic t_reset;
        @(posedge sys_clk);
        first_byte  <= 8'hFF;
        second_byte <= 8'hC0;
        ptr_high    <= 4'h0;
        ptr_low     <= 4'h0;
        instr_valid <= 1'b1;
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        reset <= 1'b1;
        #1 chk("rst_addr", 12'h000, mem_addr);
        chk("rst_wdata", 12'h000, 12'(mem_wdata));
        chk("rst_flags", 12'h000,
            12'({busy, mem_rd, mem_wr, carry_wr, carry_out, skip_next, done, illegal}));
        @(posedge sys_clk);
        reset <= 1'b0;
        run(8'hFF, 8'hC0, 4'h0, 4'h0, 4'hA, 1'b0, 12'hFF0, 4'hB, 6'h08);
    endtask : t_reset

    task automatic stop_test;
        if (fail_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    // Watchdog well past the seventeen short instructions
    initial begin
        #200000;
        fail_count++;
        stop_test;
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        t_set;
        t_or;
        t_skip;
        t_bad;
        t_reset;
        stop_test;
    end
endmodule : tb_top

`default_nettype wire
